//--- design/pm_pkg.sv
// Package with register selects, field layouts, reset values and link types.
package pm_pkg;

	// ==========================================
	// Register selects (secondary register and opcode)
	localparam logic [3:0] CRM_CLOCK_SETUP = 4'hC;
	localparam logic [3:0] CRM_POWER_MGR = 4'hE;
	localparam logic [2:0] OP_STATUS = 3'h0;
	localparam logic [2:0] OP_DATA = 3'h1;
	localparam logic [2:0] OP_CLOCK_SETUP = 3'h0;

	// ==========================================
	// Clock setup register fields
	localparam int OUT_HI = 24;
	localparam int OUT_LO = 23;
	localparam int IN_HI = 22;
	localparam int IN_LO = 17;
	localparam int PDN_BIT = 16;
	localparam int BYP_HI = 15;
	localparam int BYP_LO = 14;
	localparam int FB_HI = 11;
	localparam int FB_LO = 4;
	localparam int BUS_HI = 3;
	localparam int BUS_LO = 0;
	localparam logic [31:0] CLOCK_SETUP_WMASK = 32'h01FF_CFFF;
	localparam logic [31:0] CLOCK_SETUP_RESET = 32'h0001_C00F;

	// ==========================================
	// Power manager status and data fields
	localparam int VER_HI = 31;
	localparam int VER_LO = 28;
	localparam int TX_IDLE_BIT = 1;
	localparam int RX_FULL_BIT = 0;
	localparam int EMU_BIT = 31;
	localparam int STATE_HI = 7;
	localparam int STATE_LO = 4;
	// Version value is arbitrary.
	localparam logic [3:0] PM_VERSION = 4'h5;

	// ==========================================
	// Power state codes
	localparam logic [3:0] PS_TURBO = 4'hF;
	localparam logic [3:0] PS_NORMAL = 4'hE;
	localparam logic [3:0] PS_SLEEP = 4'h3;
	localparam logic [3:0] PS_COMA = 4'h2;
	localparam logic [3:0] PS_HIBERNATE = 4'h1;
	localparam logic [3:0] PS_OFF = 4'h0;

	typedef struct packed {
		logic emulation;
		logic [3:0] state;
	} pm_word_t;

	typedef enum logic [1:0] {TX_IDLE, TX_REQ, TX_RELEASE} tx_state_t;

endpackage

//--- design/pm_link_if.sv
// Interface joining the core end and the power manager end.
`timescale 1ns/1ps
interface pm_link_if;
	import pm_pkg::*;
	logic tx_req;
	pm_word_t tx_data;
	logic tx_ack;
	logic rx_req;
	pm_word_t rx_data;
	logic rx_ack;
	logic lock_detect;

	modport core (output tx_req, output tx_data, input tx_ack,
		input rx_req, input rx_data, output rx_ack, input lock_detect);
	modport manager (input tx_req, input tx_data, output tx_ack,
		output rx_req, output rx_data, input rx_ack, output lock_detect);
endinterface

//--- design/pm_core_regs.sv
// Core end: clock setup register and power manager mailbox.
`timescale 1ns/1ps

// Behaviour
// - Clock setup register loads documented reset fields.
// - Power-down clamps synthesiser, lock considered lost.
// - Bypass field drives clock multiplexer selects.
// - Feedback divider field drives synthesiser.
// - Bus clock divider field sets bus ratio.
// - Output field: partner bit, lock-detect bit.
// - Input field routed to synthesiser control.
// - Status holds version, zeros between flags.
// - Status bit 1 shows transmit idle.
// - Status bit 0 shows receive full.
// - Receive read returns data and acknowledges.
// - Software reads receive only when full.
// - Receive word: emulation bit, state bits.
// - Four-bit power state encoding shared.
// - Received fields keep last programmed state.
// - Transmit write clears idle, requests manager.
// - Software writes transmit only when idle.
// - Double-ended request/acknowledge handshake to acceptance.
// - Handshake done sets transmit idle again.
// - Software checks flags before issuing commands.
// - Transmit word: emulation bit, state bits.
// - Decode c14 status/data and c12 setup.
module pm_core_regs (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// Software register port.
	input wire logic [3:0] reg_crm,
	input wire logic [2:0] reg_op,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Synthesiser and clock generator controls.
	output logic synth_power_down,
	output logic [1:0] bypass_select,
	output logic [7:0] feedback_divider,
	output logic [3:0] bus_clock_divider,
	output logic [5:0] synth_input_bits,
	output logic synth_partner_out,
	// Link to the power manager.
	pm_link_if.core link
);
	import pm_pkg::*;

	logic [31:0] setup_q;
	logic tx_idle_q;
	logic rx_full_q;
	pm_word_t rx_word_q;
	logic lock_s1_q;
	logic lock_s2_q;
	logic rx_req_s1_q;
	logic rx_req_s2_q;
	logic tx_ack_s1_q;
	logic tx_ack_s2_q;
	logic rx_ack_q;
	logic tx_req_q;
	pm_word_t tx_word_q;
	tx_state_t tx_state_q;

	// ==========================================
	// Decode
	// Commands written while the transmit channel is busy are dropped, and a
	// receive read acknowledges only while a word is held.
	wire sel_setup = (reg_crm == CRM_CLOCK_SETUP) && (reg_op == OP_CLOCK_SETUP);
	wire sel_status = (reg_crm == CRM_POWER_MGR) && (reg_op == OP_STATUS);
	wire sel_data = (reg_crm == CRM_POWER_MGR) && (reg_op == OP_DATA);
	wire setup_wr = reg_wr && sel_setup;
	wire tx_wr = reg_wr && sel_data && tx_idle_q;
	wire rx_take = reg_rd && sel_data && rx_full_q;

	// Lock is reported only while the synthesiser is powered.
	wire lock_seen = lock_s2_q && !setup_q[PDN_BIT];
	wire [31:0] setup_view = (setup_q & CLOCK_SETUP_WMASK & ~(32'h1 << OUT_LO))
		| ({31'h0, lock_seen} << OUT_LO);
	wire [31:0] status_view = {PM_VERSION, 26'h0, tx_idle_q, rx_full_q};
	wire [31:0] rx_view = {rx_word_q.emulation, 23'h0, rx_word_q.state, 4'h0};
	wire [31:0] rdata_d = sel_setup ? setup_view : sel_status ? status_view
		: sel_data ? rx_view : 32'h0;

	// ==========================================
	// Synchronisers for manager-side signals
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
			rx_req_s1_q <= 1'b0;
			rx_req_s2_q <= 1'b0;
			tx_ack_s1_q <= 1'b0;
			tx_ack_s2_q <= 1'b0;
		end else begin
			lock_s1_q <= link.lock_detect;
			lock_s2_q <= lock_s1_q;
			rx_req_s1_q <= link.rx_req;
			rx_req_s2_q <= rx_req_s1_q;
			tx_ack_s1_q <= link.tx_ack;
			tx_ack_s2_q <= tx_ack_s1_q;
		end
	end

	// ==========================================
	// Register read and clock setup register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			setup_q <= CLOCK_SETUP_RESET;
			reg_rdata <= 32'h0;
		end else begin
			if (setup_wr) begin
				setup_q <= reg_wdata & CLOCK_SETUP_WMASK;
			end
			reg_rdata <= reg_rd ? rdata_d : 32'h0;
		end
	end

	// ==========================================
	// Synthesiser outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			synth_power_down <= CLOCK_SETUP_RESET[PDN_BIT];
			bypass_select <= CLOCK_SETUP_RESET[BYP_HI:BYP_LO];
			feedback_divider <= CLOCK_SETUP_RESET[FB_HI:FB_LO];
			bus_clock_divider <= CLOCK_SETUP_RESET[BUS_HI:BUS_LO];
			synth_input_bits <= CLOCK_SETUP_RESET[IN_HI:IN_LO];
			synth_partner_out <= CLOCK_SETUP_RESET[OUT_HI];
		end else begin
			synth_power_down <= setup_q[PDN_BIT];
			bypass_select <= setup_q[BYP_HI:BYP_LO];
			feedback_divider <= setup_q[FB_HI:FB_LO];
			bus_clock_divider <= setup_q[BUS_HI:BUS_LO];
			synth_input_bits <= setup_q[IN_HI:IN_LO];
			synth_partner_out <= setup_q[OUT_HI];
		end
	end

	// ==========================================
	// Receive channel: four-phase, manager raises request with data held.
	// The received word is not cleared by reset so it keeps the last state.
	always_ff @(posedge ref_clk) begin
		if (rx_req_s2_q && !rx_ack_q && !rx_full_q) begin
			rx_word_q <= link.rx_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rx_full_q <= 1'b0;
			rx_ack_q <= 1'b0;
		end else begin
			if (rx_req_s2_q && !rx_ack_q && !rx_full_q) begin
				rx_full_q <= 1'b1;
			end else if (rx_take) begin
				rx_full_q <= 1'b0;
				rx_ack_q <= 1'b1;
			end else if (!rx_req_s2_q) begin
				rx_ack_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Transmit channel: four-phase request/acknowledge.
	// The request falls only once the acknowledge is seen, and idle returns only
	// after the acknowledge has fallen, so no command can overlap the last one.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_state_q <= TX_IDLE;
			tx_idle_q <= 1'b1;
			tx_req_q <= 1'b0;
			tx_word_q <= '0;
		end else begin
			case (tx_state_q)
				TX_IDLE: begin
					if (tx_wr) begin
						tx_word_q <= pm_word_t'({reg_wdata[EMU_BIT],
							reg_wdata[STATE_HI:STATE_LO]});
						tx_idle_q <= 1'b0;
						tx_req_q <= 1'b1;
						tx_state_q <= TX_REQ;
					end
				end
				TX_REQ: begin
					if (tx_ack_s2_q) begin
						tx_req_q <= 1'b0;
						tx_state_q <= TX_RELEASE;
					end
				end
				TX_RELEASE: begin
					if (!tx_ack_s2_q) begin
						tx_idle_q <= 1'b1;
						tx_state_q <= TX_IDLE;
					end
				end
				default: begin
					tx_state_q <= TX_IDLE;
				end
			endcase
		end
	end

	assign link.tx_req = tx_req_q;
	assign link.tx_data = tx_word_q;
	assign link.rx_ack = rx_ack_q;
endmodule

//--- design/pm_manager_end.sv
// Power manager end: accepts commands and reports the programmed state.
`timescale 1ns/1ps
module pm_manager_end (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// User side: accepted commands.
	output pm_pkg::pm_word_t cmd_word,
	output logic cmd_valid,
	// User side: state report request and lock input.
	input wire logic report_req,
	input wire logic lock_in,
	output logic report_busy,
	// Link to the core.
	pm_link_if.manager link
);
	import pm_pkg::*;

	logic tx_req_s1_q;
	logic tx_req_s2_q;
	logic rx_ack_s1_q;
	logic rx_ack_s2_q;
	logic tx_ack_q;
	logic rx_req_q;
	logic lock_q;
	pm_word_t state_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_req_s1_q <= 1'b0;
			tx_req_s2_q <= 1'b0;
			rx_ack_s1_q <= 1'b0;
			rx_ack_s2_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			tx_req_s1_q <= link.tx_req;
			tx_req_s2_q <= tx_req_s1_q;
			rx_ack_s1_q <= link.rx_ack;
			rx_ack_s2_q <= rx_ack_s1_q;
			lock_q <= lock_in;
		end
	end

	// The programmed state survives reset, as the core expects.
	always_ff @(posedge ref_clk) begin
		if (tx_req_s2_q && !tx_ack_q) begin
			state_q <= link.tx_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_ack_q <= 1'b0;
			rx_req_q <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_word <= '0;
			report_busy <= 1'b0;
		end else begin
			cmd_valid <= tx_req_s2_q && !tx_ack_q;
			if (tx_req_s2_q && !tx_ack_q) begin
				cmd_word <= link.tx_data;
			end
			tx_ack_q <= tx_req_s2_q;
			if (!rx_req_q && !rx_ack_s2_q && report_req) begin
				rx_req_q <= 1'b1;
			end else if (rx_req_q && rx_ack_s2_q) begin
				rx_req_q <= 1'b0;
			end
			report_busy <= rx_req_q || rx_ack_s2_q;
		end
	end

	assign link.tx_ack = tx_ack_q;
	assign link.rx_req = rx_req_q;
	assign link.rx_data = state_q;
	assign link.lock_detect = lock_q;
endmodule

//--- tb/pm_link_chk.sv
// Checker for the handshakes on the power manager link.
`timescale 1ns/1ps
module pm_link_chk (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// Link signals.
	input wire logic tx_req,
	input wire pm_pkg::pm_word_t tx_data,
	input wire logic tx_ack,
	input wire logic rx_req,
	input wire pm_pkg::pm_word_t rx_data,
	input wire logic rx_ack
);
	import pm_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Transmit handshake.
	sequence s_tx_start; $rose(tx_req); endsequence
	sequence s_ack_up; $rose(tx_ack); endsequence
	property p_tx_hold; tx_req && !tx_ack |=> tx_req; endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("request dropped early");
	property p_tx_data; tx_req && $past(tx_req) |-> $stable(tx_data); endproperty
	a_tx_data: assert property (p_tx_data) else $error("command moved");
	property p_ack_bound; s_tx_start |-> ##[1:10] tx_ack; endproperty
	a_ack_bound: assert property (p_ack_bound) else $error("no acceptance");
	property p_req_release; s_ack_up |-> ##[1:6] !tx_req; endproperty
	a_req_release: assert property (p_req_release) else $error("request stuck");
	property p_ack_release; tx_ack && !tx_req |-> ##[0:6] !tx_ack; endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack stuck");
	property p_no_early; tx_ack |-> !$rose(tx_req); endproperty
	a_no_early: assert property (p_no_early) else $error("request during ack");
	property p_ack_cause; !tx_req && !tx_ack |=> !tx_ack; endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack with no request");
	// ==========================================
	// Receive handshake.
	property p_rx_hold; rx_ack && rx_req |=> rx_ack; endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("receive ack dropped");
	property p_rx_cause; $rose(rx_ack) |-> rx_req; endproperty
	a_rx_cause: assert property (p_rx_cause) else $error("receive ack unasked");
	property p_rx_data; rx_req && $past(rx_req) |-> $stable(rx_data); endproperty
	a_rx_data: assert property (p_rx_data) else $error("report moved");
	sequence s_rx_drop; rx_ack && !rx_req; endsequence
	property p_rx_release; s_rx_drop |-> ##[0:6] !rx_ack; endproperty
	a_rx_release: assert property (p_rx_release) else $error("receive ack stuck");
endmodule

//--- tb/power_manager_pll_interface_tb.sv
// Testbench joining both ends of the power manager link.
`timescale 1ns/1ps
module power_manager_pll_interface_tb;
	import pm_pkg::*;
	logic ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, report_req = 0, lock_in = 1;
	logic [3:0] reg_crm = 4'h0;
	logic [2:0] reg_op = 3'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	logic synth_power_down, synth_partner_out, cmd_valid, report_busy;
	logic [1:0] bypass_select;
	logic [7:0] feedback_divider;
	logic [3:0] bus_clock_divider;
	logic [5:0] synth_input_bits;
	pm_word_t cmd_word, got;
	int mismatches = 0, checks_done = 0, ncmd = 0;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'hE, 4'hF};
	wire [21:0] outs = {synth_input_bits, synth_partner_out, synth_power_down,
		bypass_select, feedback_divider, bus_clock_divider};
	pm_link_if lk ();
	pm_core_regs i_pm_core_regs (.ref_clk, .rst_b, .reg_crm, .reg_op, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .synth_power_down, .bypass_select, .feedback_divider,
		.bus_clock_divider, .synth_input_bits, .synth_partner_out, .link(lk));
	pm_manager_end i_pm_manager_end (.ref_clk, .rst_b, .cmd_word, .cmd_valid, .report_req,
		.lock_in, .report_busy, .link(lk));
	pm_link_chk i_pm_link_chk (.ref_clk, .rst_b, .tx_req(lk.tx_req), .tx_data(lk.tx_data),
		.tx_ack(lk.tx_ack), .rx_req(lk.rx_req), .rx_data(lk.rx_data), .rx_ack(lk.rx_ack));
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (cmd_valid === 1'b1) begin
			got <= cmd_word;
			ncmd <= ncmd + 1;
		end
	end
	// ==========================================
	// Bus access, comparison and verdict.
	task close_out;
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, s, x);
		end
	endtask
	task acc(input logic [3:0] c, input logic [2:0] o, input logic [31:0] v, input logic w);
		reg_crm <= c;
		reg_op <= o;
		reg_wdata <= v;
		reg_wr <= w;
		reg_rd <= ~w;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task poll(input int b, input logic v);
		int n;
		for (n = 0; n < 60; n++) begin
			acc(CRM_POWER_MGR, OP_STATUS, 32'h0, 1'b0);
			if (d[b] === v) break;
		end
		if (n == 60) begin
			mismatches++;
			close_out();
		end
	endtask
	// ==========================================
	// Scenarios.
	task t_reset;
		acc(CRM_CLOCK_SETUP, OP_CLOCK_SETUP, 32'h0, 1'b0);
		chk(d, CLOCK_SETUP_RESET);
		chk(outs, 22'h0_700F);
		acc(CRM_POWER_MGR, OP_STATUS, 32'h0, 1'b0);
		chk(d, {PM_VERSION, 26'h0, 2'b10});
	endtask
	task t_setup;
		acc(CRM_CLOCK_SETUP, OP_CLOCK_SETUP, 32'hFFFF_FFFF, 1'b1);
		acc(CRM_CLOCK_SETUP, OP_CLOCK_SETUP, 32'h0, 1'b0);
		chk(d, 32'h017F_CFFF);
		acc(4'h1, 3'h0, 32'h0, 1'b0);
		chk(d, 32'h0);
		chk(outs, 22'h3F_FFFF);
		acc(CRM_CLOCK_SETUP, OP_CLOCK_SETUP, 32'hFE00_3A50, 1'b1);
		acc(CRM_POWER_MGR, OP_STATUS, 32'hFFFF_FFFF, 1'b1);
		acc(CRM_CLOCK_SETUP, OP_CLOCK_SETUP, 32'h0, 1'b0);
		chk(d, 32'h0080_0A50);
		chk(outs, 22'h0_0A50);
		acc(CRM_POWER_MGR, OP_STATUS, 32'h0, 1'b0);
		chk(d, {PM_VERSION, 26'h0, 2'b10});
		lock_in <= 1'b0;
		repeat (4) acc(CRM_CLOCK_SETUP, OP_CLOCK_SETUP, 32'h0, 1'b0);
		chk(d, 32'h0000_0A50);
		lock_in <= 1'b1;
	endtask
	task t_tx(input logic e, input logic [3:0] s);
		int c;
		c = ncmd;
		poll(1, 1'b1);
		chk(d[1:0], 2'b10);
		acc(CRM_POWER_MGR, OP_DATA, {e, 23'h0, s, 4'h0}, 1'b1);
		acc(CRM_POWER_MGR, OP_DATA, {~e, 23'h0, ~s, 4'h0}, 1'b1);
		acc(CRM_POWER_MGR, OP_STATUS, 32'h0, 1'b0);
		chk(d[1], 1'b0);
		poll(1, 1'b1);
		chk(ncmd, c + 1);
		chk(got, {e, s});
	endtask
	task t_rx(input logic [31:0] x);
		report_req <= 1'b1;
		poll(0, 1'b1);
		report_req <= 1'b0;
		chk(report_busy, 1'b1);
		acc(CRM_POWER_MGR, OP_DATA, 32'h0, 1'b0);
		chk(d, x);
		poll(0, 1'b0);
		repeat (12) @(posedge ref_clk);
		#1 chk(report_busy, 1'b0);
	endtask
	task t_rst;
		rst_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_setup();
		for (int i = 0; i < 9; i++) t_tx(~i[0], codes[i]);
		t_rx(32'h8000_00F0);
		t_rst();
		t_reset();
		t_rx(32'h8000_00F0);
		close_out();
	end
endmodule
